// [tb/hvpwm_ctrl_asserts.sv]
// Checker for the PWM and high-voltage output control block.
// Assumes it is bound to hvpwm_ctrl and sees only its ports.
`timescale 1ns/1ps
module hvpwm_ctrl_asserts (
  input logic MCLK, // Clock
  input logic ARST_N, // Reset, active low
  input logic [2:0] ADDR, // Register index
  input logic [7:0] WDATA, // Write data
  input logic WR, // Write strobe
  input logic RD, // Read strobe
  input logic [7:0] RDATA, // Read data
  input logic [1:0] PWM_OUT, // PWM levels
  input logic [1:0] TOP_GATE_DRIVE, // Top drives
  input logic [1:0] BOTTOM_GATE_DRIVE // Bottom drives
);
  // ==========================================================
  // Shadow of the control bits, updated at the same edge as the block
  reg [3:0] en;
  reg [7:0] sel;
  reg run;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en <= 4'h0;
      sel <= 8'h00;
      run <= 1'b0;
    end else if (WR) begin
      if (ADDR == 3'h0) en <= WDATA[3:0];
      if (ADDR == 3'h1) sel <= WDATA;
      if (ADDR == 3'h2) run <= WDATA[7];
    end
  end
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  no_shoot_a: assert property (
    (BOTTOM_GATE_DRIVE & ~TOP_GATE_DRIVE) == 2'b00)
    else $error("bottom on without top");
  float_off_a: assert property (
    !en[0] |-> TOP_GATE_DRIVE[0] && !BOTTOM_GATE_DRIVE[0])
    else $error("disabled output not floating");
  low_side_a: assert property (
    !en[3] |-> !BOTTOM_GATE_DRIVE[1])
    else $error("low side on while disabled");
  static_hi_a: assert property (
    en[0] && !sel[5] && sel[0] |->
      TOP_GATE_DRIVE[0] == 1'b0 && BOTTOM_GATE_DRIVE[0] == 1'b0)
    else $error("static high not driven");
  route_one_a: assert property (
    en[2] && sel[7:6] == 2'h2 |-> TOP_GATE_DRIVE[1] == !PWM_OUT[0])
    else $error("channel 1 not following PWM0");
  route_zero_a: assert property (
    en[0] && sel[5:4] == 2'h3 |-> TOP_GATE_DRIVE[0] == !PWM_OUT[1])
    else $error("channel 0 not following PWM1");
  pwm_idle_a: assert property (
    !run |=> PWM_OUT == 2'b00)
    else $error("PWM active while disabled");
  unmapped_rd_a: assert property (
    RD && ADDR > 3'h4 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  ctrl_gap_a: assert property (
    RD && ADDR == 3'h2 |=> RDATA[4:2] == 3'b000)
    else $error("unused control bits not zero");
  cover property (run && PWM_OUT[0]);
  cover property (RD && ADDR > 3'h4);
  cover property (en[0] && sel[5:4] == 2'h3);
endmodule // hvpwm_ctrl_asserts
bind hvpwm_ctrl hvpwm_ctrl_asserts i_hvpwm_ctrl_asserts (.MCLK(MCLK),
  .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PWM_OUT(PWM_OUT), .TOP_GATE_DRIVE(TOP_GATE_DRIVE),
  .BOTTOM_GATE_DRIVE(BOTTOM_GATE_DRIVE));

// [tb/hvpwm_mos_model.sv]
// Model of the external transistor pair on each high-voltage output.
// Assumes gate drives come straight from the block; bottom 1 = transistor on, top 0 = transistor on.
`timescale 1ns/1ps
module hvpwm_mos_model (
  input logic [1:0] top_on, // Top drive per channel
  input logic [1:0] bottom_on, // Bottom drive per channel
  output logic [1:0] at_supply, // Pin at high supply
  output logic [1:0] at_ground, // Pin at ground
  output logic [1:0] shorted // Forbidden drive pair seen
);
  // ==========================================================
  // Pin level; a pin that is neither is floating
  assign at_supply = ~top_on & ~bottom_on;
  assign at_ground = bottom_on;
  assign shorted = bottom_on & ~top_on;
endmodule // hvpwm_mos_model

// [tb/test_hvpwm_ctrl.sv]
// Testbench for hvpwm_ctrl: register port, gate encoding, PWM timing.
// Assumes the checker binds itself and the transistor model is compiled.
`timescale 1ns/1ps
module test_hvpwm_ctrl;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [7:0] rdata;
  wire [1:0] pwm_out, top, bot, up, dn, shorted;
  int error_cnt = 0;
  int compares = 0;
  localparam logic [7:0] MASKS [0:5] =
    '{8'h0F, 8'hF3, 8'hE3, 8'hFF, 8'hFF, 8'h00};
  // Enable, select, gate pair, pin level per entry
  localparam logic [23:0] GT [0:3] =
    '{24'h0F_01A6, 24'h05_00C0, 24'h00_53C0, 24'h0F_5259};
  always #12.5 mclk = ~mclk;
  hvpwm_ctrl i_hvpwm_ctrl (.MCLK(mclk), .ARST_N(arst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PWM_OUT(pwm_out),
    .TOP_GATE_DRIVE(top), .BOTTOM_GATE_DRIVE(bot));
  hvpwm_mos_model i_hvpwm_mos_model (.top_on(top), .bottom_on(bot),
    .at_supply(up), .at_ground(dn), .shorted(shorted));
  // ==========================================================
  // Bus cycles and comparison
  task chk(input string what, input [7:0] seen, input [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr_reg(input [2:0] a, input [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rd_reg(input [2:0] a, output [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task t_regs;
    reg [7:0] d;
    for (int a = 0; a < 6; a++) begin
      wr_reg(a[2:0], 8'hFF);
      rd_reg(a[2:0], d);
      chk("readback", d, MASKS[a]);
      wr_reg(a[2:0], 8'h00);
    end
    $display("test regs done");
  endtask
  task t_gates;
    for (int i = 0; i < 4; i++) begin
      wr_reg(3'h0, GT[i][23:16]);
      wr_reg(3'h1, GT[i][15:8]);
      #1 chk("gates", {4'h0, top, bot}, {4'h0, GT[i][7:4]});
      chk("pins", {2'b00, shorted, up, dn}, {4'h0, GT[i][3:0]});
    end
    $display("test gates done");
  endtask
  task t_pwm;
    int hi0, hi1, up0, up1;
    logic [1:0] prev;
    wr_reg(3'h3, 8'h05);
    wr_reg(3'h4, 8'h03);
    wr_reg(3'h0, 8'h05);
    wr_reg(3'h1, 8'hB0);
    for (int p = 0; p < 4; p++) begin
      wr_reg(3'h2, {1'b1, p[1:0], 5'h02});
      repeat (4) @(posedge mclk);
      #1 prev = pwm_out;
      {hi0, hi1, up0, up1} = '0;
      repeat (256 * (p + 1)) begin
        @(posedge mclk);
        #1 hi0 += pwm_out[0];
        hi1 += pwm_out[1];
        up0 += pwm_out[0] & !prev[0];
        up1 += pwm_out[1] & !prev[1];
        prev = pwm_out;
      end
      chk("high0", 8'(hi0), 8'(5 * (p + 1)));
      chk("pulses0", 8'(up0), 8'h04);
      chk("high1", 8'(hi1), 8'(3 * (p + 1)));
      chk("pulses1", 8'(up1), 8'h02);
      wr_reg(3'h2, 8'h00);
    end
    repeat (2) @(posedge mclk);
    #1 chk("pwm off", {6'h00, pwm_out}, 8'h00);
    $display("test pwm done");
  endtask
  // Duty rewritten mid-cycle must wait for the next full cycle
  task t_duty;
    int hi;
    wr_reg(3'h3, 8'h05);
    wr_reg(3'h2, 8'h80);
    for (int w = 0; w < 2; w++) begin
      hi = 0;
      for (int k = 0; k < 256; k++) begin
        @(posedge mclk);
        if (w == 0 && k == 50) begin
          addr <= 3'h3;
          wdata <= 8'h0C;
          wr <= 1'b1;
        end
        if (w == 0 && k == 51) wr <= 1'b0;
        #1 hi += pwm_out[0];
      end
      chk("duty swap", 8'(hi), (w == 0) ? 8'h05 : 8'h0C);
    end
    wr_reg(3'h2, 8'h00);
    $display("test duty done");
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs;
    t_gates;
    t_pwm;
    t_duty;
    complete_run;
  end
  // Full run is near 3200 cycles; this allows ample margin
  initial begin
    #500000;
    error_cnt++;
    complete_run;
  end
endmodule // test_hvpwm_ctrl

// [verilog/hvpwm_ctrl.v]
// Two 8-bit PWM channels and the digital control of two high-voltage
// driver outputs, with the anti-shoot-through gate stage.
// Assumes registers reached over a plain synchronous strobe port.
`timescale 1ns/1ps
`include "hvpwm_defines.vh"

module hvpwm_ctrl #(
  parameter CHANNELS = 2
) (
  input wire MCLK, // System clock, 40 MHz
  input wire ARST_N, // Asynchronous reset, active low
  input wire [2:0] ADDR, // Register index
  input wire [7:0] WDATA, // Write data
  input wire WR, // Write strobe
  input wire RD, // Read strobe
  output reg [7:0] RDATA, // Read data, cycle after RD
  output wire [1:0] PWM_OUT, // Raw PWM channel levels
  output wire [1:0] TOP_GATE_DRIVE, // Top transistor off, per channel
  output wire [1:0] BOTTOM_GATE_DRIVE // Bottom transistor on, per channel
);

  // ==========================================================
  // Registers
  reg [7:0] hv_output_enable_ctrl;
  reg [7:0] hv_output_select_data;
  reg [7:0] pwm_control;
  reg [7:0] pwm_duty_value [0:CHANNELS-1];
  reg [7:0] next_rdata;

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hv_output_enable_ctrl <= `RESET_REG;
      hv_output_select_data <= `RESET_REG;
      pwm_control <= `RESET_REG;
      pwm_duty_value[0] <= `RESET_REG;
      pwm_duty_value[1] <= `RESET_REG;
    end else if (WR) begin
      case (ADDR)
        `ADDR_HV_OUTPUT_ENABLE_CTRL:
          hv_output_enable_ctrl <= WDATA & `MASK_HV_OUTPUT_ENABLE_CTRL;
        `ADDR_HV_OUTPUT_SELECT_DATA:
          hv_output_select_data <= WDATA & `MASK_HV_OUTPUT_SELECT_DATA;
        `ADDR_PWM_CONTROL:
          pwm_control <= WDATA & `MASK_PWM_CONTROL;
        `ADDR_PWM_DUTY_VALUE0: pwm_duty_value[0] <= WDATA;
        `ADDR_PWM_DUTY_VALUE1: pwm_duty_value[1] <= WDATA;
        default: ;
      endcase
    end
  end

  // Unmapped indices read as zero
  always @* begin
    case (ADDR)
      `ADDR_HV_OUTPUT_ENABLE_CTRL: next_rdata = hv_output_enable_ctrl;
      `ADDR_HV_OUTPUT_SELECT_DATA: next_rdata = hv_output_select_data;
      `ADDR_PWM_CONTROL: next_rdata = pwm_control;
      `ADDR_PWM_DUTY_VALUE0: next_rdata = pwm_duty_value[0];
      `ADDR_PWM_DUTY_VALUE1: next_rdata = pwm_duty_value[1];
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ==========================================================
  // Prescaler: one-cycle tick every 1..4 system clocks
  wire pwm_global_enable = pwm_control[`BIT_PWM_GLOBAL_ENABLE];
  wire [1:0] pwm_prescale_select =
    pwm_control[`BIT_PRESCALE_SELECT+1:`BIT_PRESCALE_SELECT];
  reg [1:0] prescale_count;
  wire tick = pwm_global_enable &&
              (prescale_count == pwm_prescale_select);

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prescale_count <= 2'h0;
    end else if (!pwm_global_enable || tick) begin
      prescale_count <= 2'h0;
    end else begin
      prescale_count <= prescale_count + 2'h1;
    end
  end

  // ==========================================================
  // Shared 8-bit cycle counter; a cycle is 256 ticks
  reg [7:0] cycle_count;

  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cycle_count <= 8'h00;
    end else if (!pwm_global_enable) begin
      cycle_count <= 8'h00;
    end else if (tick) begin
      cycle_count <= cycle_count + 8'h01;
    end
  end

  // ==========================================================
  // Per-channel PWM and high-voltage output path
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      reg [7:0] duty_live;
      reg level;
      wire pwm_type_select = pwm_control[`BIT_TYPE_SELECT0 + ch];
      // Latched duty; loaded while idle or as a new cycle begins, so
      // a cycle never mixes two duty values
      wire load = !pwm_global_enable || (tick && cycle_count == 8'hFF);
      // Four sub-cycles of 64 or two of 128
      wire [6:0] phase = pwm_type_select ? cycle_count[6:0] :
                         {1'b0, cycle_count[5:0]};
      wire [1:0] sub_index = pwm_type_select ? {1'b0, cycle_count[7]} :
                             cycle_count[7:6];
      wire [6:0] base_count = pwm_type_select ? duty_live[7:1] :
                              {1'b0, duty_live[7:2]};
      wire [1:0] extra_count = pwm_type_select ? {1'b0, duty_live[0]} :
                               duty_live[1:0];
      wire [7:0] high_len = {1'b0, base_count} +
                            {7'h00, (sub_index < extra_count)};

      always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
          duty_live <= 8'h00;
        end else if (load) begin
          duty_live <= pwm_duty_value[ch];
        end
      end

      // Registered level: high from the start of each sub-cycle
      always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
          level <= 1'b0;
        end else if (!pwm_global_enable) begin
          level <= 1'b0;
        end else begin
          level <= ({1'b0, phase} < high_len);
        end
      end
      assign PWM_OUT[ch] = level;

      // Output control
      wire hv_channel_output_enable =
        hv_output_enable_ctrl[`BIT_OUTPUT_ENABLE0 + 2*ch];
      wire low_side_enable =
        hv_output_enable_ctrl[`BIT_LOW_SIDE_ENABLE0 + 2*ch];
      wire hv_static_level = hv_output_select_data[`BIT_STATIC_LEVEL0 + ch];
      wire [1:0] hv_source_select =
        hv_output_select_data[`BIT_SOURCE_SELECT0+2*ch+1:
                              `BIT_SOURCE_SELECT0+2*ch];
      reg channel_function_level;
      reg top_gate_request;
      reg bottom_gate_request;

      always @* begin
        case (hv_source_select)
          `SRC_PWM0: channel_function_level = PWM_OUT[0];
          `SRC_PWM1: channel_function_level = PWM_OUT[1];
          default: channel_function_level = hv_static_level;
        endcase
        if (!hv_channel_output_enable) begin
          top_gate_request = 1'b1;
          bottom_gate_request = 1'b0;
        end else begin
          top_gate_request = !channel_function_level;
          // Low side only when enabled; software keeps it clear for PWM
          bottom_gate_request = !channel_function_level &&
                                low_side_enable;
        end
      end

      // Bottom request always forces the top drive high too, so both never conduct
      // through the opposite pair: 01 becomes 11
      assign TOP_GATE_DRIVE[ch] = top_gate_request ||
                                  bottom_gate_request;
      assign BOTTOM_GATE_DRIVE[ch] = bottom_gate_request;
    end
  endgenerate

endmodule // hvpwm_ctrl

// [verilog/hvpwm_defines.vh]
// Register map, field positions and reset values of the PWM and
// high-voltage output control block. Definitions only.
`ifndef HVPWM_DEFINES_VH
`define HVPWM_DEFINES_VH
// ==========================================================
// Register indices on the plain register port
`define ADDR_HV_OUTPUT_ENABLE_CTRL 3'h0
`define ADDR_HV_OUTPUT_SELECT_DATA 3'h1
`define ADDR_PWM_CONTROL 3'h2
`define ADDR_PWM_DUTY_VALUE0 3'h3
`define ADDR_PWM_DUTY_VALUE1 3'h4
// ==========================================================
// Implemented-bit masks and reset values
`define MASK_HV_OUTPUT_ENABLE_CTRL 8'h0F
`define MASK_HV_OUTPUT_SELECT_DATA 8'hF3
`define MASK_PWM_CONTROL 8'hE3
`define RESET_REG 8'h00
// ==========================================================
// Field positions
`define BIT_OUTPUT_ENABLE0 0
`define BIT_LOW_SIDE_ENABLE0 1
`define BIT_STATIC_LEVEL0 0
`define BIT_SOURCE_SELECT0 4
`define BIT_PWM_GLOBAL_ENABLE 7
`define BIT_PRESCALE_SELECT 5
`define BIT_TYPE_SELECT0 0
// ==========================================================
// Source select codes (upper bit set means PWM source)
`define SRC_PWM0 2'h2
`define SRC_PWM1 2'h3
`endif
